// file: lmc_mode_ctrl.sv
// Mode, pin and watchdog control of the LIN system basis logic.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Function
// - After power-up the block starts in fail-safe with the regulator on.
// - Supply undervoltage blocks any dominant drive of the bus.
// - In normal mode transmit low drives dominant; high or open stays recessive.
// - In fail-safe the transmit pin becomes an output showing the fail-safe cause.
// - Receive output follows the bus: high recessive, low dominant.
// - In fail-safe receive shows the cause; unpowered it is switched off.
// - Enable high selects normal mode with both paths active.
// - Enable low with transmit high selects silent; no transmission, regulator on.
// - Enable low with transmit low selects sleep; no transmission, regulator off.
// - Strap low enables the watchdog in fail-safe and normal mode; strap high disables it.
// - Reset output pulls low on regulator undervoltage or watchdog failure.
// - A disabled watchdog switches its timing bias off.
// - A kick held low for the minimum trigger time registers a watchdog trigger.
// - Divider output follows divider enable, with no time limit.
// - In sleep the divider enable is ignored and the divider stays off.
// - An open divider enable reads low, leaving the divider off.
// - Transmit low past the timeout forces recessive until high long enough.
// - A low reset output in normal mode moves the block to fail-safe.
// - Rate select high in normal mode selects fast edges; low slope control.
module lmc_mode_ctrl #(
   parameter int unsigned DOM_CYC = lmc_pkg::LMC_DOM_CYC,
   parameter int unsigned RST_CYC = lmc_pkg::LMC_RST_CYC,
   parameter int unsigned WDOG_CYC = lmc_pkg::LMC_WDOG_CYC
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // AXI4-Lite slave
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [lmc_pkg::LMC_ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [lmc_pkg::LMC_ADDR_W-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // Sense and host pins
   input wire logic i_supply_uv,
   input wire logic i_reg_uv,
   input wire logic i_enable,
   input wire logic i_txd_i,
   input wire logic i_lin_rx,
   input wire logic i_wdog_strap,
   input wire logic i_wdog_kick_n,
   input wire logic i_divider_enable,
   input wire logic i_fast_rate_select,
   input wire logic i_reset_out_n_i,
   // Transmit pin driven in fail-safe
   output logic o_txd_o,
   output logic o_txd_oe,
   // Receive pin
   output logic o_rxd,
   output logic o_rxd_oe,
   // Open-drain reset pin
   output logic o_reset_out_n_o,
   output logic o_reset_out_n_oe,
   // Bus, regulator, watchdog bias, divider
   output logic o_lin_dom,
   output logic o_fast_mode,
   output logic o_regulator_on,
   output logic o_wdog_bias_on,
   output logic o_divider_on,
   output var lmc_pkg::lmc_mode_e o_mode
);
   import lmc_pkg::*;

   lmc_pins_s pins_raw;
   lmc_pins_s s;
   lmc_mode_e mode_q;
   lmc_mode_e mode_d;
   logic [1:0] fs_src_q;
   logic ctrl_dom_en_q;
   logic [31:0] dom_cnt_q;
   logic [31:0] rec_cnt_q;
   logic dom_lock_q;
   logic [31:0] rst_cnt_q;
   logic rst_req;
   logic wd_en;
   logic wd_trig;
   logic wd_fail;
   logic [LMC_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   lmc_status_s status;

   if (DOM_CYC < 2 || RST_CYC < 3 || WDOG_CYC < 2)
   begin : g_bad
      $error("lmc_mode_ctrl: counts too small");
   end

   function automatic logic hit(input logic [LMC_ADDR_W-1:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   // ***********************************************
   // Pin synchronisation
   // ***********************************************
   // Open transmit and kick pins read high, an open divider enable reads low.
   assign pins_raw = '{i_supply_uv, i_reg_uv, i_enable, i_txd_i, i_lin_rx,
                       i_wdog_strap, i_wdog_kick_n, i_divider_enable,
                       i_fast_rate_select, i_reset_out_n_i};
   lmc_sync #(.W($bits(lmc_pins_s)), .RST_VAL(LMC_PINS_IDLE)) u_sync (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_d(pins_raw),
      .o_q(s)
   );

   // ***********************************************
   // Mode state machine
   // ***********************************************
   always_comb
   begin
      mode_d = mode_q;
      case (mode_q)
         LMC_FAILSAFE:
            if (s.enable && s.rst_pin)
               mode_d = LMC_NORMAL;
         LMC_NORMAL:
            if (!s.rst_pin)
               mode_d = LMC_FAILSAFE;
            else if (!s.enable)
               mode_d = s.txd ? LMC_SILENT : LMC_SLEEP;
         LMC_SILENT, LMC_SLEEP:
            if (s.enable)
               mode_d = LMC_NORMAL;
         default:
            mode_d = LMC_FAILSAFE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         mode_q <= LMC_FAILSAFE;
      else
         mode_q <= mode_d;
   end

   // The cause is caught on the way into fail-safe and held until the next entry.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         fs_src_q <= LMC_FS_POWER_ON;
      else if (mode_q == LMC_NORMAL && mode_d == LMC_FAILSAFE)
         fs_src_q <= s.reg_uv ? LMC_FS_REG_UV :
                     (rst_cnt_q != 32'h0) ? LMC_FS_WDOG : LMC_FS_EXT_RST;
   end

   // ***********************************************
   // Dominant timeout
   // ***********************************************
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         dom_cnt_q <= '0;
         rec_cnt_q <= '0;
         dom_lock_q <= 1'b0;
      end
      else if (!ctrl_dom_en_q)
      begin
         dom_cnt_q <= '0;
         rec_cnt_q <= '0;
         dom_lock_q <= 1'b0;
      end
      else if (!s.txd)
      begin
         rec_cnt_q <= '0;
         if (dom_cnt_q < DOM_CYC)
            dom_cnt_q <= dom_cnt_q + 32'h1;
         else
            dom_lock_q <= 1'b1;
      end
      else
      begin
         dom_cnt_q <= '0;
         if (dom_lock_q && rec_cnt_q >= LMC_REC_CYC - 1)
            dom_lock_q <= 1'b0;
         else if (dom_lock_q)
            rec_cnt_q <= rec_cnt_q + 32'h1;
      end
   end

   // ***********************************************
   // Watchdog and reset output
   // ***********************************************
   // The host's kick must stay low TRIG_CYC cycles to be counted.
   assign wd_en = !s.wdog_strap && (mode_q == LMC_FAILSAFE || mode_q == LMC_NORMAL);
   lmc_wdog #(.TRIG_CYC(LMC_TRIG_CYC), .TIMEOUT_CYC(WDOG_CYC)) u_wdog (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_en(wd_en),
      .i_kick_n(s.kick_n),
      .o_trig(wd_trig),
      .o_fail(wd_fail)
   );

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rst_cnt_q <= '0;
      else if (wd_fail)
         rst_cnt_q <= RST_CYC;
      else if (rst_cnt_q != 32'h0)
         rst_cnt_q <= rst_cnt_q - 32'h1;
   end
   assign rst_req = s.reg_uv || rst_cnt_q != 32'h0;

   // ***********************************************
   // Pin outputs
   // ***********************************************
   // The receive driver stays off in reset, standing in for the unpowered state.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_txd_o <= 1'b1;
         o_txd_oe <= 1'b0;
         o_rxd <= 1'b1;
         o_rxd_oe <= 1'b0;
         o_reset_out_n_o <= 1'b0;
         o_reset_out_n_oe <= 1'b0;
         o_lin_dom <= 1'b0;
         o_fast_mode <= 1'b0;
         o_regulator_on <= 1'b1;
         o_wdog_bias_on <= 1'b0;
         o_divider_on <= 1'b0;
         o_mode <= LMC_FAILSAFE;
      end
      else
      begin
         o_txd_o <= fs_src_q[0];
         o_txd_oe <= (mode_q == LMC_FAILSAFE);
         o_rxd <= (mode_q == LMC_FAILSAFE) ? fs_src_q[1] : s.lin_rx;
         o_rxd_oe <= 1'b1;
         o_reset_out_n_o <= 1'b0;
         o_reset_out_n_oe <= rst_req;
         o_lin_dom <= mode_q == LMC_NORMAL && !s.txd && !s.supply_uv && !dom_lock_q;
         o_fast_mode <= mode_q == LMC_NORMAL && s.fast_sel;
         o_regulator_on <= (mode_q != LMC_SLEEP);
         o_wdog_bias_on <= wd_en;
         o_divider_on <= s.div_en && mode_q != LMC_SLEEP;
         o_mode <= mode_q;
      end
   end

   // ***********************************************
   // AXI4-Lite slave
   // ***********************************************
   // One write and one read at a time; ready drops until the response is taken.
   assign wr_go = !o_awready && !o_wready && !o_bvalid;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= LMC_RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            awaddr_q <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready)
         begin
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (wr_go)
         begin
            o_bvalid <= 1'b1;
            o_bresp <= (hit(awaddr_q, LMC_OFS_CTRL) || hit(awaddr_q, LMC_OFS_STATUS)) ?
                       LMC_RESP_OKAY : LMC_RESP_SLVERR;
         end
         if (o_bvalid && i_bready)
         begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         ctrl_dom_en_q <= LMC_CTRL_DOM_EN_RST;
      else if (wr_go && hit(awaddr_q, LMC_OFS_CTRL) && wstrb_q[0])
         ctrl_dom_en_q <= wdata_q[LMC_CTRL_DOM_EN_BIT];
   end

   assign status = '{zero: '0, dom_locked: dom_lock_q, wdog_en: wd_en,
                     rst_active: rst_req, supply_uv: s.supply_uv,
                     fs_src: fs_src_q, mode: mode_q};

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= LMC_RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rresp <= LMC_RESP_OKAY;
         if (hit(i_araddr, LMC_OFS_CTRL))
            o_rdata <= {31'h0, ctrl_dom_en_q};
         else if (hit(i_araddr, LMC_OFS_STATUS))
            o_rdata <= status;
         else
         begin
            o_rdata <= '0;
            o_rresp <= LMC_RESP_SLVERR;
         end
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   // Counts how long transmit has stood high, so the lock release is judged on its own.
   logic [31:0] hi_run_q;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         hi_run_q <= '0;
      else if (!s.txd)
         hi_run_q <= '0;
      else if (hi_run_q < LMC_REC_CYC)
         hi_run_q <= hi_run_q + 32'h1;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   chk_failsafe_reg_on: assert property (
      mode_q == LMC_FAILSAFE |=> o_regulator_on) else $error("regulator off in fail-safe");
   chk_uv_no_dom: assert property (
      s.supply_uv |=> !o_lin_dom) else $error("dominant during undervoltage");
   chk_tx_dom: assert property (
      mode_q == LMC_NORMAL && !s.txd && !s.supply_uv && !dom_lock_q |=> o_lin_dom)
      else $error("transmit low not dominant");
   chk_fs_txd_out: assert property (
      mode_q == LMC_FAILSAFE |=> o_txd_oe && o_txd_o == $past(fs_src_q[0]))
      else $error("transmit pin not driving cause");
   chk_rx_follow: assert property (
      mode_q != LMC_FAILSAFE |=> o_rxd == $past(s.lin_rx)) else $error("receive not following bus");
   chk_silent_entry: assert property (
      mode_q == LMC_NORMAL && s.rst_pin && !s.enable && s.txd |=> mode_q == LMC_SILENT ##1
      o_regulator_on) else $error("silent entry wrong");
   chk_sleep_entry: assert property (
      mode_q == LMC_NORMAL && s.rst_pin && !s.enable && !s.txd |=> mode_q == LMC_SLEEP ##1
      (!o_regulator_on && !o_lin_dom)) else $error("sleep entry wrong");
   chk_reset_pull: assert property (
      wd_fail |-> ##2 o_reset_out_n_oe [*3]) else $error("reset not pulled after watchdog failure");
   chk_bias_off: assert property (
      s.wdog_strap |=> !o_wdog_bias_on) else $error("bias on with watchdog disabled");
   chk_div_sleep: assert property (
      mode_q == LMC_SLEEP |=> !o_divider_on) else $error("divider on in sleep");
   chk_dom_lock: assert property (
      $fell(dom_lock_q) && ctrl_dom_en_q |-> hi_run_q >= LMC_REC_CYC)
      else $error("lock released too early");
   chk_rst_failsafe: assert property (
      mode_q == LMC_NORMAL && !s.rst_pin |=> mode_q == LMC_FAILSAFE ##1 o_txd_oe)
      else $error("reset did not force fail-safe");
   chk_axi_bresp: assert property (
      wr_go |=> o_bvalid && !o_awready && !o_wready) else $error("write response missing");

   cov_normal_tx: cover property (mode_q == LMC_NORMAL ##1 o_lin_dom);
   cov_sleep: cover property (mode_q == LMC_NORMAL ##1 mode_q == LMC_SLEEP);
   cov_wd_fail: cover property (wd_fail ##1 o_reset_out_n_oe);
   cov_lock: cover property ($rose(dom_lock_q));
endmodule
`default_nettype wire

// file: lmc_pkg.sv
// Shared constants and types of the LIN mode control block.
`default_nettype none
package lmc_pkg;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int unsigned LMC_CLK_PERIOD_NS = 5;
   localparam int unsigned LMC_DOM_TIMEOUT_MS = 27;
   localparam int unsigned LMC_DOM_CYC =
      (LMC_DOM_TIMEOUT_MS * 1000000 + LMC_CLK_PERIOD_NS - 1) / LMC_CLK_PERIOD_NS;
   localparam int unsigned LMC_REC_MIN_US = 10;
   localparam int unsigned LMC_REC_CYC =
      (LMC_REC_MIN_US * 1000 + LMC_CLK_PERIOD_NS - 1) / LMC_CLK_PERIOD_NS;
   localparam int unsigned LMC_TRIG_MIN_NS = 1000;
   localparam int unsigned LMC_TRIG_CYC =
      (LMC_TRIG_MIN_NS + LMC_CLK_PERIOD_NS - 1) / LMC_CLK_PERIOD_NS;
   localparam int unsigned LMC_RST_TIME_MS = 4;
   localparam int unsigned LMC_RST_CYC =
      (LMC_RST_TIME_MS * 1000000 + LMC_CLK_PERIOD_NS - 1) / LMC_CLK_PERIOD_NS;
   localparam int unsigned LMC_WDOG_TIMEOUT_MS = 20;
   localparam int unsigned LMC_WDOG_CYC =
      (LMC_WDOG_TIMEOUT_MS * 1000000) / LMC_CLK_PERIOD_NS;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam int unsigned LMC_ADDR_W = 4;
   localparam logic [3:0] LMC_OFS_CTRL = 4'h0;
   localparam logic [3:0] LMC_OFS_STATUS = 4'h4;
   localparam int unsigned LMC_CTRL_DOM_EN_BIT = 0;
   localparam logic LMC_CTRL_DOM_EN_RST = 1'b1;
   localparam logic [1:0] LMC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LMC_RESP_SLVERR = 2'h2;
   // ***********************************************
   // Modes and fail-safe sources
   // ***********************************************
   typedef enum logic [1:0] {
      LMC_FAILSAFE = 2'b00,
      LMC_NORMAL = 2'b01,
      LMC_SILENT = 2'b10,
      LMC_SLEEP = 2'b11
   } lmc_mode_e;
   localparam logic [1:0] LMC_FS_POWER_ON = 2'h0;
   localparam logic [1:0] LMC_FS_REG_UV = 2'h1;
   localparam logic [1:0] LMC_FS_WDOG = 2'h2;
   localparam logic [1:0] LMC_FS_EXT_RST = 2'h3;
   typedef struct packed {
      logic supply_uv;
      logic reg_uv;
      logic enable;
      logic txd;
      logic lin_rx;
      logic wdog_strap;
      logic kick_n;
      logic div_en;
      logic fast_sel;
      logic rst_pin;
   } lmc_pins_s;
   // Idle levels: transmit, bus, kick and the reset pin rest high; enable rests low.
   localparam lmc_pins_s LMC_PINS_IDLE = 10'h069;
   typedef struct packed {
      logic [23:0] zero;
      logic dom_locked;
      logic wdog_en;
      logic rst_active;
      logic supply_uv;
      logic [1:0] fs_src;
      lmc_mode_e mode;
   } lmc_status_s;
endpackage
`default_nettype wire

// file: lmc_sync.sv
// Two-flop synchroniser for a vector of pin levels.
`timescale 1ns/100ps
`default_nettype none
module lmc_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         meta_q <= RST_VAL;
         o_q <= RST_VAL;
      end
      else
      begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: lmc_wdog.sv
// Watchdog: qualified kick detection and timeout.
`timescale 1ns/100ps
`default_nettype none
module lmc_wdog #(
   parameter int unsigned TRIG_CYC = 200,
   parameter int unsigned TIMEOUT_CYC = 4000000
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Control and kick
   input wire logic i_en,
   input wire logic i_kick_n,
   // Events
   output logic o_trig,
   output logic o_fail
);
   logic [31:0] low_q;
   logic [31:0] tmo_q;
   if (TRIG_CYC < 1 || TIMEOUT_CYC < 2)
   begin : g_bad
      $error("lmc_wdog: counts too small");
   end
   // A kick counts once, when the low phase after a falling edge reaches its minimum.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         low_q <= '0;
         o_trig <= 1'b0;
      end
      else
      begin
         o_trig <= 1'b0;
         if (!i_en || i_kick_n)
            low_q <= '0;
         else if (low_q < TRIG_CYC)
         begin
            low_q <= low_q + 32'h1;
            o_trig <= (low_q == TRIG_CYC - 1);
         end
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         tmo_q <= '0;
         o_fail <= 1'b0;
      end
      else
      begin
         o_fail <= 1'b0;
         if (!i_en || o_trig)
            tmo_q <= '0;
         else if (tmo_q == TIMEOUT_CYC - 1)
         begin
            tmo_q <= '0;
            o_fail <= 1'b1;
         end
         else
            tmo_q <= tmo_q + 32'h1;
      end
   end
endmodule
`default_nettype wire

// file: lmc_host_model.sv
// Behavioural model of the host microcontroller on the pin side of the block.
`timescale 1ns/100ps
`default_nettype none
module lmc_host_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Requests from the bench
   input wire logic i_en_req,
   input wire logic i_txd_req,
   input wire logic i_div_req,
   input wire logic i_auto_kick,
   // Transmit pin as driven by the device
   input wire logic i_dut_txd_o,
   input wire logic i_dut_txd_oe,
   // Pins towards the device
   output logic o_enable,
   output var logic o_txd,
   output logic o_kick_n,
   output logic o_div_en
);
   int cnt;
   // The host yields the transmit line while the device drives it.
   assign o_txd = i_dut_txd_oe ? i_dut_txd_o : i_txd_req;
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         cnt <= 0;
      else
         cnt <= (cnt == 299) ? 0 : cnt + 1;
   end
   // Low for 210 cycles so that each kick clears the minimum trigger time.
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_kick_n <= 1'b1;
      else
         o_kick_n <= !(i_auto_kick && cnt < 210);
   end
   always_ff @(posedge i_clk)
   begin
      o_enable <= i_en_req;
      o_div_en <= i_div_req;
   end
endmodule
`default_nettype wire

// file: test_lin_transceiver_mode_control.sv
// Self-checking bench of the LIN mode control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
   begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_lin_transceiver_mode_control;
   import lmc_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
   logic [3:0] awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, d;
   logic [1:0] r;
   logic suv = 1'b0, ruv = 1'b0, strap = 1'b0, fast = 1'b0, bus = 1'b1, ak = 1'b1;
   logic en_q = 1'b0, txd_q = 1'b1, div_q = 1'b0;
   logic awr, wr, bv, arr, rv, en, txd, kick, div, txo, txoe, rxd, rxoe, ro, roe;
   logic dom, fm, reg_on, bias, div_on;
   logic [1:0] br, rr;
   logic [31:0] rd;
   lmc_mode_e mode;
   int fail_count = 0, check_count = 0;
   initial forever #2.5 clk = ~clk;
   lmc_mode_ctrl #(.DOM_CYC(50), .RST_CYC(10), .WDOG_CYC(500)) u_dut (.i_clk(clk),
      .i_resetn(rstn), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
      .o_wready(wr), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(bq),
      .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
      .i_rready(rq), .o_rdata(rd), .o_rresp(rr), .i_supply_uv(suv), .i_reg_uv(ruv),
      .i_enable(en), .i_txd_i(txd), .i_lin_rx(bus & ~dom), .i_wdog_strap(strap),
      .i_wdog_kick_n(kick), .i_divider_enable(div), .i_fast_rate_select(fast),
      .i_reset_out_n_i(~roe), .o_txd_o(txo), .o_txd_oe(txoe), .o_rxd(rxd), .o_rxd_oe(rxoe),
      .o_reset_out_n_o(ro), .o_reset_out_n_oe(roe), .o_lin_dom(dom), .o_fast_mode(fm),
      .o_regulator_on(reg_on), .o_wdog_bias_on(bias), .o_divider_on(div_on), .o_mode(mode));
   lmc_host_model u_host (.i_clk(clk), .i_resetn(rstn), .i_en_req(en_q), .i_txd_req(txd_q),
      .i_div_req(div_q), .i_auto_kick(ak), .i_dut_txd_o(txo), .i_dut_txd_oe(txoe),
      .o_enable(en), .o_txd(txd), .o_kick_n(kick), .o_div_en(div));
   // ***********************************************
   // Bus tasks
   // ***********************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v, output logic [1:0] s);
      int n = 0;
      bit ta = 0, tw = 0;
      awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= v; bq <= 1'b1;
      while (!(ta && tw) && n < 100)
      begin
         @(posedge clk);
         n++;
         if (awr && awv) ta = 1;
         if (wr && wv) tw = 1;
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      do @(posedge clk); while (!bv && n++ < 100);
      s = br; bq <= 1'b0;
      if (n >= 100) fail_count++;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v, output logic [1:0] s);
      int n = 0;
      arv <= 1'b1; ara <= a; rq <= 1'b1;
      do @(posedge clk); while (!arr && n++ < 100);
      arv <= 1'b0;
      do @(posedge clk); while (!rv && n++ < 100);
      v = rd; s = rr; rq <= 1'b0;
      if (n >= 100) fail_count++;
      @(posedge clk);
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_power;
      cyc(8);
      `CHK("mode", LMC_FAILSAFE, mode)
      `CHK("regulator", 1'b1, reg_on)
      `CHK("txd oe", 1'b1, txoe)
      `CHK("txd cause", LMC_FS_POWER_ON[0], txo)
      `CHK("rxd cause", LMC_FS_POWER_ON[1], rxd)
      `CHK("rxd oe", 1'b1, rxoe)
      `CHK("bias", 1'b1, bias)
      rd_reg(LMC_OFS_CTRL, d, r);
      `CHK("ctrl reset", 32'h00000001, d)
   endtask
   task automatic t_normal;
      en_q <= 1'b1; cyc(8);
      `CHK("mode", LMC_NORMAL, mode)
      txd_q <= 1'b0; cyc(8);
      `CHK("dom", 1'b1, dom)
      `CHK("rxd", 1'b0, rxd)
      txd_q <= 1'b1; fast <= 1'b1; cyc(6);
      `CHK("dom", 1'b0, dom)
      `CHK("fast", 1'b1, fm)
      bus <= 1'b0; fast <= 1'b0; cyc(6);
      `CHK("rxd", 1'b0, rxd)
      `CHK("fast", 1'b0, fm)
      bus <= 1'b1; suv <= 1'b1; txd_q <= 1'b0; cyc(6);
      `CHK("rxd", 1'b1, rxd)
      `CHK("dom uv", 1'b0, dom)
      suv <= 1'b0; cyc(6);
      `CHK("dom", 1'b1, dom)
      txd_q <= 1'b1; cyc(6);
   endtask
   task automatic t_timeout;
      txd_q <= 1'b0; cyc(70);
      `CHK("dom lock", 1'b0, dom)
      rd_reg(LMC_OFS_STATUS, d, r);
      `CHK("lock bit", 1'b1, d[7])
      txd_q <= 1'b1; cyc(1000); txd_q <= 1'b0; cyc(6);
      `CHK("dom early", 1'b0, dom)
      txd_q <= 1'b1; cyc(2010); txd_q <= 1'b0; cyc(6);
      `CHK("dom again", 1'b1, dom)
      txd_q <= 1'b1; cyc(6);
      wr_reg(LMC_OFS_CTRL, 32'h0, r);
      txd_q <= 1'b0; cyc(70);
      `CHK("dom no lock", 1'b1, dom)
      txd_q <= 1'b1; cyc(2);
      wr_reg(LMC_OFS_CTRL, 32'h1, r);
   endtask
   task automatic t_low_modes;
      div_q <= 1'b1; cyc(6);
      `CHK("div", 1'b1, div_on)
      en_q <= 1'b0; cyc(8);
      `CHK("mode", LMC_SILENT, mode)
      `CHK("regulator", 1'b1, reg_on)
      `CHK("div", 1'b1, div_on)
      txd_q <= 1'b0; cyc(6);
      `CHK("dom", 1'b0, dom)
      txd_q <= 1'b1; div_q <= 1'b0; en_q <= 1'b1; cyc(8);
      `CHK("div", 1'b0, div_on)
      `CHK("mode", LMC_NORMAL, mode)
      txd_q <= 1'b0; cyc(2); en_q <= 1'b0; cyc(8);
      `CHK("mode", LMC_SLEEP, mode)
      `CHK("regulator", 1'b0, reg_on)
      `CHK("dom", 1'b0, dom)
      div_q <= 1'b1; cyc(6);
      `CHK("div", 1'b0, div_on)
      txd_q <= 1'b1; div_q <= 1'b0; en_q <= 1'b1; cyc(8);
   endtask
   task automatic t_wdog;
      int n = 0;
      ak <= 1'b0;
      do @(posedge clk); while (!roe && n++ < 800);
      `CHK("reset pulled", 1'b1, roe)
      `CHK("reset level", 1'b0, ro)
      cyc(6);
      `CHK("mode", LMC_FAILSAFE, mode)
      `CHK("txd cause", LMC_FS_WDOG[0], txo)
      `CHK("rxd cause", LMC_FS_WDOG[1], rxd)
      ak <= 1'b1; n = 0;
      // Regular kicks must keep the reset pin released for several timeouts.
      repeat (1500)
      begin
         @(posedge clk);
         if (roe) n++;
      end
      `CHK("kicked", 1'b0, n > 20)
      `CHK("mode", LMC_NORMAL, mode)
      ruv <= 1'b1; cyc(6);
      `CHK("reset uv", 1'b1, roe)
      ruv <= 1'b0; strap <= 1'b1; ak <= 1'b0; cyc(30);
      `CHK("bias", 1'b0, bias)
      n = 0;
      repeat (800)
      begin
         @(posedge clk);
         if (roe) n++;
      end
      `CHK("wdog off", 0, n)
      strap <= 1'b0; ak <= 1'b1; cyc(8);
   endtask
   task automatic t_regs;
      rd_reg(LMC_OFS_STATUS, d, r);
      `CHK("status mode", LMC_NORMAL, d[1:0])
      `CHK("status resp", LMC_RESP_OKAY, r)
      rd_reg(4'h8, d, r);
      `CHK("unmapped rd", LMC_RESP_SLVERR, r)
      `CHK("unmapped data", 32'h0, d)
      wr_reg(4'hC, 32'h0, r);
      `CHK("unmapped wr", LMC_RESP_SLVERR, r)
      wr_reg(LMC_OFS_STATUS, 32'h0, r);
      `CHK("ro wr", LMC_RESP_OKAY, r)
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      cyc(2);
      `CHK("rxd oe unpowered", 1'b0, rxoe)
      rstn <= 1'b1;
      t_power();
      t_normal();
      t_timeout();
      t_low_modes();
      t_wdog();
      t_regs();
      summarize();
   end
   initial
   begin
      cyc(60000);
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
